// ==== include/pll_cfg_pkg.sv ====
// Shared constants for the synthesizer configuration latch logic
package pll_cfg_pkg;
    // ----------------------------------------------------------------
    // Word and latch select
    // ----------------------------------------------------------------
    localparam int LATCH_W = 24;
    localparam logic [1:0] SEL_FUNC = 2'h0;
    localparam logic [1:0] SEL_REF = 2'h1;
    localparam logic [1:0] SEL_FDBK = 2'h2;
    localparam logic [23:0] LATCH_RST = 24'h00_0000;

    // ----------------------------------------------------------------
    // Function latch fields
    // ----------------------------------------------------------------
    localparam int CORE_LSB = 2;
    localparam int CNT_RST_BIT = 4;
    localparam int MUX_LSB = 5;
    localparam int POL_BIT = 8;
    localparam int HIZ_BIT = 9;
    localparam int GAIN_BIT_F = 10;
    localparam int MUTE_BIT = 11;
    localparam int PWR_LSB = 12;
    localparam int CUR1_LSB = 14;
    localparam int CUR2_LSB = 17;

    // ----------------------------------------------------------------
    // Feedback divider latch fields
    // ----------------------------------------------------------------
    localparam int SWAL_LSB = 2;
    localparam int SWAL_W = 5;
    localparam int MAIN_LSB = 8;
    localparam int MAIN_W = 13;
    localparam int GAIN_BIT_N = 21;
    localparam int HALVE_BIT = 22;
    localparam int SRC_BIT = 23;

    // ----------------------------------------------------------------
    // Reference divider latch fields
    // ----------------------------------------------------------------
    localparam int REFDIV_LSB = 2;
    localparam int REFDIV_W = 14;
    localparam int BACKLASH_LSB = 16;
    localparam int PREC_BIT = 18;
    localparam int TEST_BIT = 19;
    localparam int BAND_LSB = 20;

    // ----------------------------------------------------------------
    // Lock detect and output mux
    // ----------------------------------------------------------------
    localparam logic [2:0] LOCK_CYC_FINE = 3'h5;
    localparam logic [2:0] LOCK_CYC_COARSE = 3'h3;
    localparam logic [2:0] MUX_LOW = 3'h0;
    localparam logic [2:0] MUX_LOCK = 3'h1;
    localparam logic [2:0] MUX_FDBK = 3'h2;
    localparam logic [2:0] MUX_HIGH = 3'h3;
    localparam logic [2:0] MUX_REF = 3'h4;
    localparam logic [2:0] MUX_BAND = 3'h5;
    localparam logic [2:0] MUX_MODCTL = 3'h6;

    typedef enum logic {st_unlocked, st_locked} lock_state_t;
endpackage

// ==== verilog/mod_counter.sv ====
// Modulo counter that pulses once every MOD steps
`timescale 1ns/1ps
module mod_counter #(
    parameter int W = 14
) (
    input logic ref_clk,
    input logic sys_rst,
    input logic clear,
    input logic step,
    input logic [W-1:0] modulus,
    output logic tick
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic at_end;

    // Wrap at modulus minus one, at once if the modulus was lowered; zero never ticks
    always_comb begin
        at_end = (modulus != '0) && (cnt_q >= modulus - W'(1));
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (clear) begin
            cnt_d = '0;
        end else if (step) begin
            if (at_end) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else if (modulus != '0) begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    // Count registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// ==== verilog/pll_synth_latch_config.sv ====
// Configuration latches, dividers and lock detect of an integer-N synthesizer
//
// Function
// - Function latch holds pump current setting one and setting two, three bits each.
// - Two-bit output power field selects VCO output power.
// - Mute bit keeps RF outputs off until lock is reported.
// - Gain bit picks pump current two when 1, current one when 0.
// - Three-state bit at 1 floats pump output; host writes 0 normally.
// - Polarity bit 1 is positive, 0 is negative.
// - Three-bit select field chooses the multiplexed output pin source.
// - Counter reset bit holds reference and A, B counters in reset.
// - Feedback latch carries five-bit A value, 0 through 31.
// - Feedback latch carries 13-bit B value, 3 through 8191.
// - Total division equals prescaler modulus times B plus A.
// - Gain bits in function and feedback latches share one flag, latest wins.
// - Bit 22 of feedback latch enables output divide-by-two.
// - Bit 23 of feedback latch feeds halved signal to prescaler.
// - Control bits 0,1 route word to reference divider latch.
// - Reference latch carries 14-bit divide ratio, 1 through 16383.
// - Reference latch bits 16,17 select antibacklash pulse width.
// - Lock after five good reference cycles if precision bit set, else three.
// - Test bit 0 means normal latches only; host always writes 0.
// - Band-select clock field optionally divides reference counter output.
// - Control bits 0,0 route word to function latch.
// - 24 bits shift on serial clock rises; strobe rise latches them.
`timescale 1ns/1ps
module pll_synth_latch_config #(
    parameter int PRESCALE = 8,
    parameter int RATIO_W = 24
) (
    input logic ref_clk,
    input logic sys_rst,
    input logic ser_clk,
    input logic ser_data,
    input logic latch_strobe,
    input logic phase_ok,
    input logic presc_pulse,
    output logic [2:0] pump_current_sel,
    output logic pump_hiz,
    output logic detector_polarity,
    output logic pump_gain_flag,
    output logic [1:0] out_power,
    output logic [1:0] core_current,
    output logic rf_out_en,
    output logic counters_held,
    output logic halve_output,
    output logic prescaler_src_sel,
    output logic modulus_plus_one,
    output logic [RATIO_W-1:0] feedback_ratio,
    output logic [1:0] backlash_width,
    output logic lock_precision,
    output logic factory_test_flag,
    output logic ref_tick,
    output logic band_clk_tick,
    output logic fdbk_tick,
    output logic lock_detect,
    output logic multiplexed_output_pin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------------------------------
    // Serial input register
    // ----------------------------------------------------------------
    logic [23:0] shift_q;
    logic [23:0] shift_d;
    logic ser_clk_q;
    logic strobe_q;
    logic ser_rise;
    logic strobe_rise;

    // Shift on serial clock rise, spot strobe rise
    always_comb begin
        ser_rise = ser_clk && !ser_clk_q;
        strobe_rise = latch_strobe && !strobe_q;
        shift_d = shift_q;
        if (ser_rise) begin
            shift_d = {shift_q[22:0], ser_data};
        end
    end

    // Serial registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_q <= pll_cfg_pkg::LATCH_RST;
            ser_clk_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            ser_clk_q <= ser_clk;
            strobe_q <= latch_strobe;
        end
    end

    a_shift_edge: assert property (ser_rise |=> shift_q == {$past(shift_q[22:0]),
        $past(ser_data)}) else $error("serial bit not shifted in");

    // ----------------------------------------------------------------
    // Latches
    // ----------------------------------------------------------------
    logic [23:0] func_q;
    logic [23:0] func_d;
    logic [23:0] fdbk_q;
    logic [23:0] fdbk_d;
    logic [23:0] refl_q;
    logic [23:0] refl_d;
    logic gain_q;
    logic gain_d;
    logic [1:0] sel;

    // Route strobed word by its control bits
    always_comb begin
        sel = shift_q[1:0];
        func_d = func_q;
        fdbk_d = fdbk_q;
        refl_d = refl_q;
        gain_d = gain_q;
        if (strobe_rise) begin
            if (sel == pll_cfg_pkg::SEL_FUNC) begin
                func_d = shift_q;
                gain_d = shift_q[pll_cfg_pkg::GAIN_BIT_F];
            end else if (sel == pll_cfg_pkg::SEL_REF) begin
                refl_d = shift_q;
            end else if (sel == pll_cfg_pkg::SEL_FDBK) begin
                fdbk_d = shift_q;
                gain_d = shift_q[pll_cfg_pkg::GAIN_BIT_N];
            end
        end
    end

    // Latch registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            func_q <= pll_cfg_pkg::LATCH_RST;
            fdbk_q <= pll_cfg_pkg::LATCH_RST;
            refl_q <= pll_cfg_pkg::LATCH_RST;
            gain_q <= 1'b0;
        end else begin
            func_q <= func_d;
            fdbk_q <= fdbk_d;
            refl_q <= refl_d;
            gain_q <= gain_d;
        end
    end

    sequence s_strobe_sel(logic [1:0] code);
        strobe_rise && (shift_q[1:0] == code);
    endsequence

    a_route_func: assert property (s_strobe_sel(pll_cfg_pkg::SEL_FUNC) |=>
        func_q == $past(shift_q)) else $error("function latch not loaded");
    a_route_ref: assert property (s_strobe_sel(pll_cfg_pkg::SEL_REF) |=>
        refl_q == $past(shift_q) && func_q == $past(func_q))
        else $error("reference latch misrouted");
    a_route_fdbk: assert property (s_strobe_sel(pll_cfg_pkg::SEL_FDBK) |=>
        fdbk_q == $past(shift_q) && refl_q == $past(refl_q))
        else $error("feedback latch misrouted");
    a_gain_latest: assert property (s_strobe_sel(pll_cfg_pkg::SEL_FDBK) |=>
        pump_gain_flag == $past(shift_q[pll_cfg_pkg::GAIN_BIT_N]))
        else $error("gain flag stale");

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    logic [2:0] cur1;
    logic [2:0] cur2;
    logic [4:0] swallow_val;
    logic [12:0] main_val;
    logic [13:0] refdiv_val;
    logic [1:0] band_sel;
    logic cnt_reset;
    logic mute_req;

    // Slice latches into named fields
    always_comb begin
        cur1 = func_q[pll_cfg_pkg::CUR1_LSB +: 3];
        cur2 = func_q[pll_cfg_pkg::CUR2_LSB +: 3];
        cnt_reset = func_q[pll_cfg_pkg::CNT_RST_BIT];
        mute_req = func_q[pll_cfg_pkg::MUTE_BIT];
        swallow_val = fdbk_q[pll_cfg_pkg::SWAL_LSB +: pll_cfg_pkg::SWAL_W];
        main_val = fdbk_q[pll_cfg_pkg::MAIN_LSB +: pll_cfg_pkg::MAIN_W];
        refdiv_val = refl_q[pll_cfg_pkg::REFDIV_LSB +: pll_cfg_pkg::REFDIV_W];
        band_sel = refl_q[pll_cfg_pkg::BAND_LSB +: 2];
    end

    // Direct register outputs
    assign pump_gain_flag = gain_q;
    assign pump_hiz = func_q[pll_cfg_pkg::HIZ_BIT];
    assign detector_polarity = func_q[pll_cfg_pkg::POL_BIT];
    assign out_power = func_q[pll_cfg_pkg::PWR_LSB +: 2];
    assign core_current = func_q[pll_cfg_pkg::CORE_LSB +: 2];
    assign counters_held = cnt_reset;
    assign halve_output = fdbk_q[pll_cfg_pkg::HALVE_BIT];
    assign prescaler_src_sel = fdbk_q[pll_cfg_pkg::SRC_BIT];
    assign backlash_width = refl_q[pll_cfg_pkg::BACKLASH_LSB +: 2];
    assign lock_precision = refl_q[pll_cfg_pkg::PREC_BIT];
    assign factory_test_flag = refl_q[pll_cfg_pkg::TEST_BIT];

    // ----------------------------------------------------------------
    // Reference and feedback counters
    // ----------------------------------------------------------------
    // Reference counter, held while counter reset is set
    mod_counter #(.W(pll_cfg_pkg::REFDIV_W)) u_ref_cnt (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(cnt_reset),
        .step(1'b1),
        .modulus(refdiv_val),
        .tick(ref_tick)
    );

    // B counter counts prescaler output pulses
    mod_counter #(.W(pll_cfg_pkg::MAIN_W)) u_main_cnt (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(cnt_reset),
        .step(presc_pulse),
        .modulus(main_val),
        .tick(fdbk_tick)
    );

    logic [4:0] swal_q;
    logic [4:0] swal_d;
    logic mpo_q;
    logic mpo_d;
    logic [RATIO_W-1:0] ratio_q;
    logic [RATIO_W-1:0] ratio_d;
    logic [2:0] band_cnt_q;
    logic [2:0] band_cnt_d;
    logic [2:0] band_mask;
    logic band_q;
    logic band_d;

    // A counter, ratio and band-select divider
    always_comb begin
        swal_d = swal_q;
        if (cnt_reset || fdbk_tick) begin
            swal_d = '0;
        end else if (presc_pulse && swal_q < swallow_val) begin
            swal_d = swal_q + 5'h1;
        end
        mpo_d = !cnt_reset && (swal_d < swallow_val);
        ratio_d = RATIO_W'(PRESCALE) * RATIO_W'(main_val)
            + RATIO_W'(swallow_val);
        case (band_sel)
            2'h0: band_mask = 3'h0;
            2'h1: band_mask = 3'h1;
            2'h2: band_mask = 3'h3;
            default: band_mask = 3'h7;
        endcase
        band_cnt_d = band_cnt_q;
        band_d = 1'b0;
        if (cnt_reset) begin
            band_cnt_d = '0;
        end else if (ref_tick) begin
            band_d = (band_cnt_q & band_mask) == band_mask;
            band_cnt_d = band_cnt_q + 3'h1;
        end
    end

    // Divider state registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            swal_q <= '0;
            mpo_q <= 1'b0;
            ratio_q <= '0;
            band_cnt_q <= '0;
            band_q <= 1'b0;
        end else begin
            swal_q <= swal_d;
            mpo_q <= mpo_d;
            ratio_q <= ratio_d;
            band_cnt_q <= band_cnt_d;
            band_q <= band_d;
        end
    end

    assign modulus_plus_one = mpo_q;
    assign feedback_ratio = ratio_q;
    assign band_clk_tick = band_q;

    a_ratio_value: assert property (##1 feedback_ratio == RATIO_W'(PRESCALE)
        * RATIO_W'($past(main_val)) + RATIO_W'($past(swallow_val)))
        else $error("feedback ratio wrong");
    sequence s_held2;
        cnt_reset [*2];
    endsequence
    a_counter_hold: assert property (s_held2 |-> !ref_tick && !fdbk_tick)
        else $error("counter ticked while held");
    a_band_from_ref: assert property (band_clk_tick |-> $past(ref_tick))
        else $error("band clock without reference tick");

    // ----------------------------------------------------------------
    // Lock detect, mute and pump current select
    // ----------------------------------------------------------------
    pll_cfg_pkg::lock_state_t lock_q;
    pll_cfg_pkg::lock_state_t lock_d;
    logic [2:0] good_q;
    logic [2:0] good_d;
    logic [2:0] need;
    logic rf_q;
    logic rf_d;
    logic [2:0] cur_q;
    logic [2:0] cur_d;

    // Count consecutive good reference cycles
    always_comb begin
        need = lock_precision ? pll_cfg_pkg::LOCK_CYC_FINE
            : pll_cfg_pkg::LOCK_CYC_COARSE;
        lock_d = lock_q;
        good_d = good_q;
        if (cnt_reset) begin
            lock_d = pll_cfg_pkg::st_unlocked;
            good_d = '0;
        end else if (ref_tick) begin
            case (lock_q)
                pll_cfg_pkg::st_unlocked: begin
                    if (!phase_ok) begin
                        good_d = '0;
                    end else if (good_q + 3'h1 >= need) begin
                        good_d = '0;
                        lock_d = pll_cfg_pkg::st_locked;
                    end else begin
                        good_d = good_q + 3'h1;
                    end
                end
                default: begin
                    if (!phase_ok) begin
                        lock_d = pll_cfg_pkg::st_unlocked;
                    end
                end
            endcase
        end
        rf_d = !(mute_req && lock_q != pll_cfg_pkg::st_locked);
        cur_d = gain_q ? cur2 : cur1;
    end

    // Lock and output registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lock_q <= pll_cfg_pkg::st_unlocked;
            good_q <= '0;
            rf_q <= 1'b0;
            cur_q <= '0;
        end else begin
            lock_q <= lock_d;
            good_q <= good_d;
            rf_q <= rf_d;
            cur_q <= cur_d;
        end
    end

    assign lock_detect = (lock_q == pll_cfg_pkg::st_locked);
    assign rf_out_en = rf_q;
    assign pump_current_sel = cur_q;

    a_mute_lock: assert property (mute_req && !lock_detect |=> !rf_out_en)
        else $error("RF on before lock");
    a_pump_select: assert property (##1 pump_current_sel ==
        ($past(gain_q) ? $past(cur2) : $past(cur1)))
        else $error("wrong pump current");
    a_lock_bad: assert property (!lock_detect && ref_tick && !phase_ok
        |=> !lock_detect) else $error("lock on bad cycle");
    a_lock_coarse: assert property (!lock_precision && !cnt_reset && ref_tick
        && phase_ok && !lock_detect && good_q == pll_cfg_pkg::LOCK_CYC_COARSE - 3'h1
        |=> lock_detect) else $error("no lock after coarse count");

    // ----------------------------------------------------------------
    // Multiplexed output pin
    // ----------------------------------------------------------------
    logic mux_q;
    logic mux_d;

    // Pick internal signal by select field
    always_comb begin
        case (func_q[pll_cfg_pkg::MUX_LSB +: 3])
            pll_cfg_pkg::MUX_LOCK: mux_d = lock_detect;
            pll_cfg_pkg::MUX_FDBK: mux_d = fdbk_tick;
            pll_cfg_pkg::MUX_HIGH: mux_d = 1'b1;
            pll_cfg_pkg::MUX_REF: mux_d = ref_tick;
            pll_cfg_pkg::MUX_BAND: mux_d = band_clk_tick;
            pll_cfg_pkg::MUX_MODCTL: mux_d = modulus_plus_one;
            default: mux_d = 1'b0;
        endcase
    end

    // Mux output register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mux_q <= 1'b0;
        end else begin
            mux_q <= mux_d;
        end
    end

    assign multiplexed_output_pin = mux_q;

    a_mux_lock: assert property (func_q[pll_cfg_pkg::MUX_LSB +: 3]
        == pll_cfg_pkg::MUX_LOCK |=> multiplexed_output_pin == $past(lock_detect))
        else $error("mux pin not lock");
endmodule

// ==== sim/host_serial_model.sv ====
// Host controller model driving the three-wire serial link
`timescale 1ns/1ps
module host_serial_model (
    input wire logic ref_clk,
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    // ------------------------------------------------------------
    // Idle levels: serial clock stands low between frames
    // ------------------------------------------------------------
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // Shift 24 bits first bit high, then pulse the strobe
    task automatic write_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge ref_clk);
            ser_clk = 1'b1;
            ser_data = w[i];
            @(negedge ref_clk);
            ser_clk = 1'b0;
            ser_data = ~w[i]; // Data line flips to the inverted bit, so no stale value lingers
        end
        @(negedge ref_clk);
        latch_strobe = 1'b1;
        @(negedge ref_clk);
        latch_strobe = 1'b0;
        @(negedge ref_clk);
    endtask
endmodule

// ==== sim/pll_synth_latch_config_tb_top.sv ====
// Self-checking testbench for the synthesizer configuration latches
`timescale 1ns/1ps
module pll_synth_latch_config_tb_top;
    logic ref_clk, sys_rst, ser_clk, ser_data, latch_strobe, phase_ok, modulus_plus_one;
    logic presc_pulse = 1'b0;
    logic [2:0] pump_current_sel;
    logic pump_hiz, detector_polarity, pump_gain_flag, rf_out_en, counters_held;
    logic [1:0] out_power, core_current, backlash_width;
    logic halve_output, prescaler_src_sel, lock_precision, factory_test_flag;
    logic [23:0] feedback_ratio;
    logic ref_tick, band_clk_tick, fdbk_tick, lock_detect, multiplexed_output_pin;
    int err_total, checks, bref, bband, bfb, bmux;
    int nref = 0, nband = 0, nfb = 0, nmux = 0, pcnt = 0;

    // ------------------------------------------------------------
    // Design and host model
    // ------------------------------------------------------------
    pll_synth_latch_config #(.PRESCALE(8), .RATIO_W(24)) u_pll_synth_latch_config (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
        .latch_strobe(latch_strobe), .phase_ok(phase_ok), .presc_pulse(presc_pulse),
        .pump_current_sel(pump_current_sel), .pump_hiz(pump_hiz),
        .detector_polarity(detector_polarity), .pump_gain_flag(pump_gain_flag),
        .out_power(out_power), .core_current(core_current), .rf_out_en(rf_out_en),
        .counters_held(counters_held), .halve_output(halve_output),
        .prescaler_src_sel(prescaler_src_sel), .modulus_plus_one(modulus_plus_one),
        .feedback_ratio(feedback_ratio), .backlash_width(backlash_width),
        .lock_precision(lock_precision), .factory_test_flag(factory_test_flag),
        .ref_tick(ref_tick), .band_clk_tick(band_clk_tick), .fdbk_tick(fdbk_tick),
        .lock_detect(lock_detect), .multiplexed_output_pin(multiplexed_output_pin));
    host_serial_model u_host_serial_model (
        .ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .latch_strobe(latch_strobe));

    // Clock and prescaler pulse every 4 cycles
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        pcnt <= (pcnt + 1) % 4;
        presc_pulse <= (pcnt == 0);
    end
    // Tick counters
    always @(posedge ref_clk) begin
        nref <= nref + int'(ref_tick);
        nband <= nband + int'(band_clk_tick);
        nfb <= nfb + int'(fdbk_tick);
        nmux <= nmux + int'(multiplexed_output_pin);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [23:0] w);
        u_host_serial_model.write_word(w);
        cyc(3);
    endtask
    task automatic zero_cnt();
        bref = nref;
        bband = nband;
        bfb = nfb;
        bmux = nmux;
    endtask
    // Wait for a tick, then hold the phase good until lock is reported
    task automatic lock_run(input int n);
        @(posedge ref_tick);
        @(negedge ref_clk);
        phase_ok = 1'b1;
        zero_cnt();
        for (int i = 0; i < 200 && lock_detect !== 1'b1; i++) cyc(1);
        chk(nref - bref, n);
    endtask
    task automatic close_out();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #(100 * 6000);
        err_total++;
        close_out();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        phase_ok = 1'b0;
        err_total = 0;
        checks = 0;
        zero_cnt();
        cyc(2);
        sys_rst = 1'b0;
        cyc(2);
        chk({pump_current_sel, out_power, feedback_ratio}, 0);
        chk(rf_out_en, 1);
        $display("test reset done");
        // Reference: R=4, backlash 2, precision 1, band /2, test 0
        wr(24'h16_0011);
        chk({factory_test_flag, lock_precision, backlash_width}, 4'h6);
        zero_cnt();
        cyc(40);
        chk(nref - bref, 10);
        chk(nband - bband, 5);
        $display("test reference done");
        // Function: cur1 3, cur2 5, power 2, mute, pol 1, mux 4, core 1
        wr(24'h0A_E984);
        chk({pump_current_sel, pump_hiz, detector_polarity}, 5'h0D);
        chk({out_power, core_current}, 4'h9);
        chk(rf_out_en, 0);
        chk(counters_held, 0);
        // Feedback: A 5, B 3, gain 1, halve 1, src 1
        wr(24'hE0_0316);
        chk(feedback_ratio, 29);
        chk({halve_output, prescaler_src_sel, modulus_plus_one}, 3'h7);
        chk({pump_gain_flag, pump_current_sel}, 4'hD);
        zero_cnt();
        cyc(48);
        chk(nfb - bfb, 4);
        $display("test latches done");
        // Lock with precision 1 takes five good ticks
        lock_run(5);
        cyc(2);
        chk(rf_out_en, 1);
        phase_ok = 1'b0;
        cyc(8);
        chk(lock_detect, 0);
        $display("test lock done");
        // Reference: R=2, backlash 2, precision 0, band /8; mux pin shows the tick
        wr(24'h32_0009);
        chk({factory_test_flag, lock_precision, backlash_width}, 4'h2);
        zero_cnt();
        cyc(32);
        chk(nref - bref, 16);
        chk(nband - bband, 2);
        chk(nmux - bmux, 16);
        // Function: gain 1, mux lock; coarse lock takes three good ticks
        wr(24'h0A_ED24);
        chk({pump_gain_flag, pump_current_sel}, 4'hD);
        lock_run(3);
        cyc(1);
        chk(multiplexed_output_pin, 1);
        phase_ok = 1'b0;
        cyc(4);
        chk({lock_detect, multiplexed_output_pin}, 2'h0);
        $display("test coarse lock done");
        // Gain through function latch wins over the feedback bit
        wr(24'h0A_E984);
        chk({pump_gain_flag, pump_current_sel}, 4'h3);
        // Three-state, gain, mux high
        wr(24'h0A_E764);
        chk({pump_hiz, pump_gain_flag, pump_current_sel}, 5'h1D);
        chk(multiplexed_output_pin, 1);
        // Counter reset holds the reference counter, mux low
        wr(24'h0A_E914);
        chk({counters_held, multiplexed_output_pin}, 2'h2);
        zero_cnt();
        cyc(40);
        chk(nref - bref + nfb - bfb, 0);
        // Control bits 11 are ignored
        wr(24'hFF_FFFF);
        chk({out_power, backlash_width, halve_output, feedback_ratio}, 29'h1500_001D);
        $display("test controls done");
        close_out();
    end
endmodule
